// File: rtl/ccs_cfg.svh
// Constants for the converter control and serial configuration port
`ifndef CCS_CFG_SVH
`define CCS_CFG_SVH
// Frame layout
`define CCS_HDR_PATTERN  12'h001
`define CCS_HDR_HI       31
`define CCS_HDR_LO       20
`define CCS_ADDR_HI      19
`define CCS_ADDR_LO      16
`define CCS_DATA_HI      15
`define CCS_FRAME_LAST   5'h1f
// Register addresses
`define CCS_A_CFG        4'h1
`define CCS_A_IOFF       4'h2
`define CCS_A_IFS        4'h3
`define CCS_A_QOFF       4'ha
`define CCS_A_QFS        4'hb
`define CCS_A_DESEN      4'hd
`define CCS_A_COARSE     4'he
// Register index space
`define CCS_NREG         7
`define CCS_IDX_NONE     3'h7
// Power-on reset values
`define CCS_RST_CFG      16'hb2ff
`define CCS_RST_OFF      16'h007f
`define CCS_RST_FS       16'h807f
`define CCS_RST_DESEN    16'h3fff
`define CCS_RST_COARSE   16'h07ff
// Field positions
`define CCS_CFG_PHASE    11
`define CCS_CFG_NDE      10
`define CCS_CFG_SWING    9
`define CCS_CFG_OE       8
`define CCS_OFF_MAG_HI   15
`define CCS_OFF_MAG_LO   8
`define CCS_OFF_SIGN     7
`define CCS_FS_LO        7
`define CCS_DES_EN       15
`define CCS_DES_ACP      14
`define CCS_CRS_IS       15
`define CCS_CRS_ADS      14
`define CCS_CRS_CAM_HI   13
`define CCS_CRS_CAM_LO   11
// Fixed values for normal mode
`define CCS_FS_NOMINAL   9'h100
`define CCS_OFF_NONE     9'h000
`define CCS_CAM_NONE     3'h0
// Timing counts in system clock cycles
`define CCS_CAL_RUN_CYC  32'h0000_0400
`define CCS_FLUSH_CYC    4'he
`define CCS_CNT_ZERO     32'h0000_0000
`define CCS_CNT_ONE      32'h0000_0001
`endif

// File: rtl/ccs_ctrl_serial_port.sv
// Converter control sequencer, control-mode select and write-only serial register port
//
// Behaviour
// - Sleep pin low means active; high means sleep, data outputs hold last result.
// - Second-channel sleep pin powers down only Q; I keeps converting.
// - No control sleeps I alone; only full sleep disables I.
// - Pipeline results invalid for a while after leaving sleep.
// - Sleep request during calibration waits until calibration completes.
// - Sleep pin high at power-up holds off the power-up calibration delay.
// - Manual calibration request during sleep is dropped, never queued.
// - Calibration skips a sleeping Q channel; host recalibrates after waking it.
// - Normal mode fixes DDR phase at zero; extended mode takes output bits from register.
// - Calibration delay chosen by pin in normal mode, short only in extended.
// - Normal: two shared full-scale choices; extended: 9-bit full scale per channel.
// - No offset in normal mode; extended gives each channel 9-bit offset.
// - Interleave samples I only in normal mode; extended selects either input.
// - Interleave phase automatic in normal; extended uses auto bit or manual delay.
// - Power-on reset loads the documented extended-mode defaults.
// - Serial port accepts frames only in extended mode.
// - Serial data sampled on each serial clock rise while select low.
// - Frame is 32 bits MSB first: header 001h, 4-bit address, 16 data.
// - Next frame may start on the 33rd clock without releasing select.
// - Address decode maps seven registers; all other codes reserved.
// - Registers are write-only, nothing reads back.
// - In normal mode register contents do not affect behaviour.
`timescale 1ns/1ps
`include "ccs_cfg.svh"

module ccs_ctrl_serial_port #(
  parameter logic [31:0] CAL_SHORT_CYC = 32'h0200_0000,
  parameter logic [31:0] CAL_LONG_CYC  = 32'h8000_0000
) (
  // Clock and reset
  input  wire logic                  sys_clk_in,
  input  wire logic                  srst_in,
  // Control pins
  input  wire logic                  sleep_request_pin_in,
  input  wire logic                  second_channel_sleep_pin_in,
  input  wire logic                  range_or_control_mode_pin_in,
  input  wire logic                  control_mode_float_in,
  input  wire logic                  sdr_select_pin_in,
  input  wire logic                  out_edge_pin_in,
  input  wire logic                  output_swing_pin_in,
  input  wire logic                  cal_delay_pin_in,
  input  wire logic                  interleave_pin_in,
  input  wire logic                  cal_request_pin_in,
  // Serial configuration pins
  input  wire logic                  cfg_serial_clk_in,
  input  wire logic                  cfg_serial_in,
  input  wire logic                  cfg_select_n_in,
  // Converter core samples
  input  wire logic [7:0]            sample_i_in,
  input  wire logic [7:0]            sample_q_in,
  // Status and data
  output logic                       cal_running_out,
  output logic                       i_awake_out,
  output logic                       q_awake_out,
  output logic                       q_cal_valid_out,
  output logic                       pipe_valid_out,
  output logic [7:0]                 data_i_out,
  output logic [7:0]                 data_q_out,
  // Effective settings
  output ccs_pkg::ccs_settings_t     settings_out
);

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Address to register index; reserved codes give the none index
  function automatic logic [2:0] addr_to_idx(input logic [3:0] addr);
    case (addr)
      `CCS_A_CFG:    addr_to_idx = 3'h0;
      `CCS_A_IOFF:   addr_to_idx = 3'h1;
      `CCS_A_IFS:    addr_to_idx = 3'h2;
      `CCS_A_QOFF:   addr_to_idx = 3'h3;
      `CCS_A_QFS:    addr_to_idx = 3'h4;
      `CCS_A_DESEN:  addr_to_idx = 3'h5;
      `CCS_A_COARSE: addr_to_idx = 3'h6;
      default:       addr_to_idx = `CCS_IDX_NONE;
    endcase
  endfunction : addr_to_idx

  // Power-on value of each register index
  function automatic logic [15:0] rst_value(input logic [2:0] idx);
    case (idx)
      3'h0:    rst_value = `CCS_RST_CFG;
      3'h1:    rst_value = `CCS_RST_OFF;
      3'h2:    rst_value = `CCS_RST_FS;
      3'h3:    rst_value = `CCS_RST_OFF;
      3'h4:    rst_value = `CCS_RST_FS;
      3'h5:    rst_value = `CCS_RST_DESEN;
      default: rst_value = `CCS_RST_COARSE;
    endcase
  endfunction : rst_value

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  localparam int NSYNC = 13;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] pin_meta_reg;
  logic [NSYNC-1:0] pin_sync_reg;
  logic             sclk_prev_reg;
  logic             cal_req_prev_reg;

  assign pin_raw = {sleep_request_pin_in, second_channel_sleep_pin_in,
                    range_or_control_mode_pin_in, control_mode_float_in,
                    sdr_select_pin_in, out_edge_pin_in, output_swing_pin_in,
                    cal_delay_pin_in, interleave_pin_in, cal_request_pin_in,
                    cfg_serial_clk_in, cfg_serial_in, cfg_select_n_in};

  // Two flops on every pin; serial pins share the same delay so data stays aligned.
  // No reset here: a sleep pin already high must be seen right after reset,
  // otherwise the power-up delay counter would creep forward for two cycles
  always_ff @(posedge sys_clk_in) begin
    pin_meta_reg <= pin_raw;
    pin_sync_reg <= pin_meta_reg;
  end

  logic sleep_s;
  logic qsleep_s;
  logic range_s;
  logic ext_s;
  logic sdr_s;
  logic edge_s;
  logic swing_s;
  logic caldly_s;
  logic des_s;
  logic calreq_s;
  logic sclk_s;
  logic sdi_s;
  logic sel_n_s;

  assign {sleep_s, qsleep_s, range_s, ext_s, sdr_s, edge_s, swing_s,
          caldly_s, des_s, calreq_s, sclk_s, sdi_s, sel_n_s} = pin_sync_reg;

  // Edge history taken from the synchronised copies only
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      sclk_prev_reg    <= 1'b0;
      cal_req_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg    <= sclk_s;
      cal_req_prev_reg <= calreq_s;
    end
  end

  logic sclk_rise;
  logic cal_req_rise;
  assign sclk_rise    = sclk_s & ~sclk_prev_reg;
  assign cal_req_rise = calreq_s & ~cal_req_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame receiver

  logic [31:0] shift_reg;
  logic [31:0] shift_next;
  logic [4:0]  bit_cnt_reg;
  logic        shift_en;
  logic        frame_done;
  logic        frame_ok;
  logic [2:0]  wr_idx;

  // Port is dead in normal mode, select high restarts the frame
  assign shift_en   = ext_s & ~sel_n_s & sclk_rise;
  assign shift_next = {shift_reg[30:0], sdi_s};
  assign frame_done = shift_en & (bit_cnt_reg == `CCS_FRAME_LAST);
  assign wr_idx     = addr_to_idx(shift_next[`CCS_ADDR_HI:`CCS_ADDR_LO]);
  assign frame_ok   = frame_done &
                      (shift_next[`CCS_HDR_HI:`CCS_HDR_LO] == `CCS_HDR_PATTERN) &
                      (wr_idx != `CCS_IDX_NONE);

  // Bit counter wraps after 32 bits so the 33rd clock opens a new frame
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || !ext_s || sel_n_s) begin
      bit_cnt_reg <= '0;
    end else if (shift_en) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      shift_reg <= '0;
    end else if (shift_en) begin
      shift_reg <= shift_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write-only register file, no read path exists at all

  logic [15:0] regfile_reg [`CCS_NREG];

  generate
    for (genvar g = 0; g < `CCS_NREG; g++) begin : g_reg
      always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
          regfile_reg[g] <= rst_value(3'(g));
        end else if (frame_ok && wr_idx == 3'(g)) begin
          regfile_reg[g] <= shift_next[`CCS_DATA_HI:0];
        end
      end
    end
  endgenerate

  logic [15:0] cfg_r;
  logic [15:0] ioff_r;
  logic [15:0] ifs_r;
  logic [15:0] qoff_r;
  logic [15:0] qfs_r;
  logic [15:0] desen_r;
  logic [15:0] coarse_r;
  assign cfg_r    = regfile_reg[0];
  assign ioff_r   = regfile_reg[1];
  assign ifs_r    = regfile_reg[2];
  assign qoff_r   = regfile_reg[3];
  assign qfs_r    = regfile_reg[4];
  assign desen_r  = regfile_reg[5];
  assign coarse_r = regfile_reg[6];

  ////////////////////////////////////////////////////////////////////////////
  // Effective settings: pins in normal mode, registers in extended mode

  ccs_pkg::ccs_settings_t set_next;

  always_comb begin
    set_next = '0;
    set_next.ext_mode = ext_s;
    if (ext_s) begin
      set_next.sdr_mode      = cfg_r[`CCS_CFG_NDE];
      set_next.ddr_phase_180 = cfg_r[`CCS_CFG_PHASE];
      set_next.out_edge_rise = cfg_r[`CCS_CFG_OE];
      set_next.swing_normal  = cfg_r[`CCS_CFG_SWING];
      set_next.long_cal_delay = 1'b0;
      set_next.i_fullscale   = ifs_r[`CCS_DATA_HI:`CCS_FS_LO];
      set_next.q_fullscale   = qfs_r[`CCS_DATA_HI:`CCS_FS_LO];
      set_next.i_offset      = {ioff_r[`CCS_OFF_SIGN],
                                ioff_r[`CCS_OFF_MAG_HI:`CCS_OFF_MAG_LO]};
      set_next.q_offset      = {qoff_r[`CCS_OFF_SIGN],
                                qoff_r[`CCS_OFF_MAG_HI:`CCS_OFF_MAG_LO]};
      set_next.des_enable    = desen_r[`CCS_DES_EN];
      set_next.des_q_input   = coarse_r[`CCS_CRS_IS];
      set_next.auto_phase    = desen_r[`CCS_DES_ACP];
      set_next.adj_dir_q     = coarse_r[`CCS_CRS_ADS];
      set_next.coarse_delay  = coarse_r[`CCS_CRS_CAM_HI:`CCS_CRS_CAM_LO];
    end else begin
      // Register contents are simply not looked at here
      set_next.sdr_mode      = sdr_s;
      set_next.ddr_phase_180 = 1'b0;
      set_next.out_edge_rise = edge_s;
      set_next.swing_normal  = swing_s;
      set_next.long_cal_delay = caldly_s;
      set_next.full_range_high = range_s;
      set_next.i_fullscale   = `CCS_FS_NOMINAL;
      set_next.q_fullscale   = `CCS_FS_NOMINAL;
      set_next.i_offset      = `CCS_OFF_NONE;
      set_next.q_offset      = `CCS_OFF_NONE;
      set_next.des_enable    = des_s;
      set_next.des_q_input   = 1'b0;
      set_next.auto_phase    = 1'b1;
      set_next.adj_dir_q     = 1'b0;
      set_next.coarse_delay  = `CCS_CAM_NONE;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      settings_out <= '0;
    end else begin
      settings_out <= set_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power and calibration sequencer

  ccs_pkg::ccs_state_t state_reg;
  ccs_pkg::ccs_state_t state_next;
  logic [31:0]         dly_cnt_reg;
  logic [31:0]         cal_cnt_reg;
  logic [31:0]         dly_target;
  logic                dly_done;
  logic                cal_done;

  // Extended mode always uses the short delay
  assign dly_target = (ext_s || !caldly_s) ? CAL_SHORT_CYC : CAL_LONG_CYC;
  assign dly_done   = (dly_cnt_reg >= dly_target - `CCS_CNT_ONE);
  assign cal_done   = (cal_cnt_reg == `CCS_CAL_RUN_CYC - `CCS_CNT_ONE);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ccs_pkg::st_por_wait: begin
        if (!sleep_s && dly_done) begin
          state_next = ccs_pkg::st_cal;
        end
      end
      ccs_pkg::st_cal: begin
        // A sleep request is only honoured once the run is over
        if (cal_done) begin
          state_next = sleep_s ? ccs_pkg::st_sleep : ccs_pkg::st_active;
        end
      end
      ccs_pkg::st_active: begin
        if (sleep_s) begin
          state_next = ccs_pkg::st_sleep;
        end else if (cal_req_rise) begin
          state_next = ccs_pkg::st_cal;
        end
      end
      ccs_pkg::st_sleep: begin
        // Requests seen here are dropped, nothing remembers them
        if (!sleep_s) begin
          state_next = ccs_pkg::st_active;
        end
      end
      default: state_next = ccs_pkg::st_por_wait;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      state_reg <= ccs_pkg::st_por_wait;
    end else begin
      state_reg <= state_next;
    end
  end

  // Delay counter frozen while the sleep pin is high after power-up
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      dly_cnt_reg <= `CCS_CNT_ZERO;
    end else if (state_reg == ccs_pkg::st_por_wait && !sleep_s && !dly_done) begin
      dly_cnt_reg <= dly_cnt_reg + `CCS_CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in || state_reg != ccs_pkg::st_cal) begin
      cal_cnt_reg <= `CCS_CNT_ZERO;
    end else begin
      cal_cnt_reg <= cal_cnt_reg + `CCS_CNT_ONE;
    end
  end

  // Q counts as calibrated only if it was awake for a whole run
  logic q_cal_ok_reg;
  logic q_slept_in_cal_reg;
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || state_reg != ccs_pkg::st_cal) begin
      q_slept_in_cal_reg <= 1'b0;
    end else if (qsleep_s) begin
      q_slept_in_cal_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      q_cal_ok_reg <= 1'b0;
    end else if (state_reg == ccs_pkg::st_cal && cal_done &&
                 !qsleep_s && !q_slept_in_cal_reg) begin
      q_cal_ok_reg <= 1'b1;
    end else if (qsleep_s) begin
      q_cal_ok_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output data hold and pipeline flush

  logic [3:0] flush_cnt_reg;

  // Flush counter reloads while asleep; pipeline holds stale samples until it drains
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      flush_cnt_reg <= `CCS_FLUSH_CYC;
    end else if (state_reg == ccs_pkg::st_sleep) begin
      flush_cnt_reg <= `CCS_FLUSH_CYC;
    end else if (state_reg == ccs_pkg::st_active && flush_cnt_reg != 4'h0) begin
      flush_cnt_reg <= flush_cnt_reg - 4'h1;
    end
  end

  // Only full sleep stops I; there is no separate I sleep input
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      data_i_out <= '0;
    end else if (state_reg == ccs_pkg::st_active) begin
      data_i_out <= sample_i_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      data_q_out <= '0;
    end else if (state_reg == ccs_pkg::st_active && !qsleep_s) begin
      data_q_out <= sample_q_in;
    end
  end

  assign cal_running_out = (state_reg == ccs_pkg::st_cal);
  assign i_awake_out     = (state_reg != ccs_pkg::st_sleep);
  assign q_awake_out     = i_awake_out & ~qsleep_s;
  assign q_cal_valid_out = q_cal_ok_reg;
  assign pipe_valid_out  = (state_reg == ccs_pkg::st_active) && (flush_cnt_reg == 4'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_sleep_holds: assert property (
    (state_reg == ccs_pkg::st_sleep) |=> $stable(data_i_out) && $stable(data_q_out))
    else $error("data changed while asleep");

  a_q_only_sleep: assert property (
    (state_reg == ccs_pkg::st_active && qsleep_s) |=>
      (data_i_out == $past(sample_i_in)) && $stable(data_q_out))
    else $error("Q sleep disturbed I or Q data");

  a_flush_after: assert property (
    (state_reg == ccs_pkg::st_sleep) ##1 (state_reg == ccs_pkg::st_active) |->
      !pipe_valid_out [*8])
    else $error("pipeline marked valid right after wake");

  a_cal_finish: assert property (
    (state_reg == ccs_pkg::st_cal && !cal_done) |=> (state_reg == ccs_pkg::st_cal))
    else $error("calibration cut short");

  a_por_hold: assert property (
    (state_reg == ccs_pkg::st_por_wait && sleep_s) |=>
      $stable(dly_cnt_reg) && (state_reg == ccs_pkg::st_por_wait))
    else $error("power-up delay ran during sleep");

  a_manual_ignored: assert property (
    (state_reg == ccs_pkg::st_sleep) |=> (state_reg != ccs_pkg::st_cal))
    else $error("calibration started from sleep");

  a_normal_phase: assert property (
    !ext_s |=> !settings_out.ddr_phase_180 && (settings_out.i_offset == `CCS_OFF_NONE))
    else $error("normal mode phase or offset not fixed");

  a_short_delay: assert property (
    ext_s |=> !settings_out.long_cal_delay)
    else $error("long delay chosen in extended mode");

  a_normal_no_write: assert property (
    !ext_s |=> $stable(cfg_r) && $stable(desen_r))
    else $error("register written in normal mode");

  a_cfg_write: assert property (
    (frame_ok && wr_idx == 3'h0) |=> (cfg_r == $past(shift_next[`CCS_DATA_HI:0])))
    else $error("config frame not stored");

  a_bad_discard: assert property (
    (frame_done && !frame_ok) |=> $stable(cfg_r) && $stable(ifs_r) && $stable(coarse_r))
    else $error("bad frame changed a register");

endmodule : ccs_ctrl_serial_port

// File: rtl/ccs_pkg.sv
// Types shared by the converter control and serial configuration port
package ccs_pkg;
  // Control sequencer states
  typedef enum logic [1:0] {
    st_por_wait,
    st_cal,
    st_active,
    st_sleep
  } ccs_state_t;

  // Effective settings presented to the converter core
  typedef struct packed {
    logic       ext_mode;
    logic       sdr_mode;
    logic       ddr_phase_180;
    logic       out_edge_rise;
    logic       swing_normal;
    logic       long_cal_delay;
    logic       full_range_high;
    logic [8:0] i_fullscale;
    logic [8:0] q_fullscale;
    logic [8:0] i_offset;
    logic [8:0] q_offset;
    logic       des_enable;
    logic       des_q_input;
    logic       auto_phase;
    logic       adj_dir_q;
    logic [2:0] coarse_delay;
  } ccs_settings_t;
endpackage : ccs_pkg

// File: tb/ccs_host_model.sv
// Host side model driving the three-wire configuration port
`timescale 1ns/1ps
module ccs_host_model (
  // Clock
  input  wire logic sys_clk_in,
  // Serial port
  output logic      cfg_serial_clk_out,
  output logic      cfg_serial_out,
  output logic      cfg_select_n_out
);
  initial begin
    cfg_serial_clk_out = 1'b0;
    cfg_serial_out = 1'b0;
    cfg_select_n_out = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Released data line toggles so a stale bit never looks valid
  always @(negedge sys_clk_in) begin
    if (cfg_select_n_out)
      cfg_serial_out <= ~cfg_serial_out;
  end

  task automatic step(input int k);
    repeat (k) @(posedge sys_clk_in);
    #1;
  endtask : step

  // Sends nbits of a frame; sclk stands still low between bits and frames
  task automatic send(input logic [31:0] f, input int nbits, input bit keep);
    for (int i = 31; i > 31 - nbits; i--) begin
      step(1);
      cfg_select_n_out = 1'b0;
      cfg_serial_out = f[i];
      step(4);
      cfg_serial_clk_out = 1'b1;
      step(4);
      cfg_serial_clk_out = 1'b0;
    end
    step(4);
    if (!keep)
      cfg_select_n_out = 1'b1;
  endtask : send
endmodule : ccs_host_model

// File: tb/converter_ctrl_serial_port_bench.sv
// Self-checking bench for the converter control and serial configuration port
`timescale 1ns/1ps
module converter_ctrl_serial_port_bench;
  logic clk, rst, slp, qslp, rng, ext, sdr, edg, swg, cdly, ilv, creq;
  logic sck, sdi, sel_n, cal, iaw, qaw, qcv, pv;
  logic [7:0] si, sq, di, dq;
  logic [15:0] hold;
  ccs_pkg::ccs_settings_t st;
  logic [15:0] mreg [16];
  logic [3:0] addrs [7] = '{4'h1, 4'h2, 4'h3, 4'ha, 4'hb, 4'hd, 4'he};
  int mismatches, tests_run, seed, n, m;

  ccs_ctrl_serial_port #(.CAL_SHORT_CYC(32'h10), .CAL_LONG_CYC(32'h20)) uut (
    .sys_clk_in(clk), .srst_in(rst), .sleep_request_pin_in(slp),
    .second_channel_sleep_pin_in(qslp), .range_or_control_mode_pin_in(rng),
    .control_mode_float_in(ext), .sdr_select_pin_in(sdr), .out_edge_pin_in(edg),
    .output_swing_pin_in(swg), .cal_delay_pin_in(cdly), .interleave_pin_in(ilv),
    .cal_request_pin_in(creq), .cfg_serial_clk_in(sck), .cfg_serial_in(sdi),
    .cfg_select_n_in(sel_n), .sample_i_in(si), .sample_q_in(sq),
    .cal_running_out(cal), .i_awake_out(iaw), .q_awake_out(qaw),
    .q_cal_valid_out(qcv), .pipe_valid_out(pv), .data_i_out(di),
    .data_q_out(dq), .settings_out(st));
  ccs_host_model host (.sys_clk_in(clk), .cfg_serial_clk_out(sck),
    .cfg_serial_out(sdi), .cfg_select_n_out(sel_n));

  ////////////////////////////////////////////////////////////////////////////
  // 200 MHz system clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Converter samples change every cycle so held data is visible
  always @(posedge clk) begin
    si <= #1 8'($random(seed));
    sq <= #1 8'($random(seed));
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  // Bounded wait for the calibration flag; n returns the cycles spent
  task automatic wait_cal(input logic lvl, input int lim);
    n = 0;
    while (cal !== lvl) begin
      tick(1);
      n++;
      if (n > lim) begin
        mismatches++;
        tally_and_finish();
      end
    end
  endtask : wait_cal

  // Manual calibration; sleep pin may be raised once it is running
  task automatic man_cal(input logic s);
    creq = 1'b1;
    wait_cal(1'b1, 20);
    creq = 1'b0;
    slp = s;
    wait_cal(1'b0, 1100);
  endtask : man_cal

  // Keeps the bits that must read as one set
  function automatic logic [15:0] legal(input logic [3:0] a, input logic [15:0] r);
    case (a)
      4'h1: return (r & 16'h1f00) | 16'ha0ff;
      4'hd: return (r & 16'hc000) | 16'h3fff;
      4'he: return (r & 16'hf800) | 16'h07ff;
      default: return (r & 16'hff80) | 16'h007f;
    endcase
  endfunction : legal

  // One frame, mirrored in the reference copy only when it should land
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input bit ok, input bit keep);
    host.send({ok ? 12'h001 : 12'h003, a, d}, 32, keep);
    if (ok && ext && a inside {4'h1, 4'h2, 4'h3, 4'ha, 4'hb, 4'hd, 4'he})
      mreg[a] = d;
  endtask : wr

  // Effective settings against the reference copy
  task automatic cmp_regs();
    check(st.ext_mode, 1);
    check(st.ddr_phase_180, mreg[1][11]);
    check(st.sdr_mode, mreg[1][10]);
    check(st.swing_normal, mreg[1][9]);
    check(st.out_edge_rise, mreg[1][8]);
    check(st.i_offset, {mreg[2][7], mreg[2][15:8]});
    check(st.i_fullscale, mreg[3][15:7]);
    check(st.q_offset, {mreg[10][7], mreg[10][15:8]});
    check(st.q_fullscale, mreg[11][15:7]);
    check(st.des_enable, mreg[13][15]);
    check(st.auto_phase, mreg[13][14]);
    check(st.des_q_input, mreg[14][15]);
    check(st.adj_dir_q, mreg[14][14]);
    check(st.coarse_delay, mreg[14][13:11]);
    check(st.long_cal_delay, 0);
  endtask : cmp_regs

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 91;
    {qslp, rng, sdr, edg, swg, cdly, ilv, creq, si, sq} = '0;
    {ext, slp, rst} = 3'h7;
    mismatches = 0;
    tests_run = 0;
    mreg = '{default: 16'h0000};
    mreg[1] = 16'hb2ff;
    mreg[2] = 16'h007f;
    mreg[3] = 16'h807f;
    mreg[10] = 16'h007f;
    mreg[11] = 16'h807f;
    mreg[13] = 16'h3fff;
    mreg[14] = 16'h07ff;
    tick(8);
    rst = 1'b0;
    tick(60);
    check(cal, 0);
    slp = 1'b0;
    wait_cal(1'b1, 60);
    wait_cal(1'b0, 1100);
    check(n, 1024);
    tick(4);
    cmp_regs();
    // Middle round runs back to back with select held low
    for (int r = 0; r < 3; r++) begin
      foreach (addrs[k])
        wr(addrs[k], legal(addrs[k], 16'($random(seed))), 1, r == 1);
      tick(8);
      cmp_regs();
    end
    wr(4'h3, 16'h007f, 0, 0);
    wr(4'h4, 16'h007f, 1, 0);
    wr(4'hf, 16'h007f, 1, 0);
    host.send({12'h001, 4'h3, 16'hffff}, 20, 0);
    tick(8);
    cmp_regs();
    man_cal(1'b1);
    check(n, 1024);
    tick(4);
    check({iaw, qaw}, 2'b00);
    hold = {di, dq};
    creq = 1'b1;
    tick(4);
    creq = 1'b0;
    tick(20);
    check({di, dq}, hold);
    slp = 1'b0;
    n = 0;
    m = 0;
    repeat (40) begin
      tick(1);
      n += int'(cal !== 1'b0);
      m += int'(pv !== 1'b1);
    end
    check(n, 0);
    check(m >= 14 && pv === 1'b1, 1);
    qslp = 1'b1;
    tick(5);
    check({iaw, qaw, qcv}, 3'b100);
    hold = {di, dq};
    tick(3);
    check(dq, hold[7:0]);
    man_cal(1'b0);
    check(qcv, 0);
    qslp = 1'b0;
    man_cal(1'b0);
    tick(2);
    check({qaw, qcv}, 2'b11);
    // Mode pin changes only under reset
    {rst, ext, sdr, rng, cdly} = 5'h17;
    tick(8);
    rst = 1'b0;
    tick(10);
    wr(4'h1, 16'ha0ff, 1, 0);
    tick(8);
    check({st.ext_mode, st.sdr_mode}, 2'b01);
    check(st.ddr_phase_180, 0);
    check({st.full_range_high, st.i_fullscale}, 10'h300);
    check(st.i_offset, 0);
    check(st.des_q_input, 0);
    check(st.auto_phase, 1);
    check(st.long_cal_delay, 1);
    tally_and_finish();
  end
endmodule : converter_ctrl_serial_port_bench
